// File: verilog/lcd_instr_pkg.sv
// holds the shared constants of the character display instruction decoder
// assumes a 10 MHz mclk; all times are turned into cycle counts here
package lcd_instr_pkg;

    // ----------------------------------------
    // clock and execution times
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_CMD_NS = 39000;
    localparam int T_DATA_NS = 43000;
    localparam int T_CLEAR_NS = 1530000;
    localparam int CMD_CYC = (T_CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_CYC = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYC = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W = 16;
    localparam logic [11:0] BLINK_HALF_CYC = 12'h0_FA0;

    // ----------------------------------------
    // text memory address map
    // ----------------------------------------
    localparam logic [6:0] ADDR_ZERO = 7'h00;
    localparam logic [6:0] ONE_LINE_END = 7'h4F;
    localparam logic [6:0] LINE1_END = 7'h27;
    localparam logic [6:0] LINE2_START = 7'h40;
    localparam logic [6:0] LINE2_END = 7'h67;
    localparam logic [6:0] FILL_LAST = 7'h7F;
    localparam logic [6:0] SPAN_ONE_LINE = 7'h50;
    localparam logic [6:0] SPAN_TWO_LINE = 7'h28;
    localparam logic [7:0] SPACE_CODE = 8'h20;

    // ----------------------------------------
    // command field positions
    // ----------------------------------------
    localparam int BIT_DISP_ON = 2;
    localparam int BIT_CURSOR_ON = 1;
    localparam int BIT_BLINK_ON = 0;
    localparam int BIT_STEP_UP = 1;
    localparam int BIT_AUTO_SHIFT = 0;
    localparam int BIT_SHIFT_TARGET = 3;
    localparam int BIT_SHIFT_DIR = 2;
    localparam int BIT_BUS_WIDTH = 4;
    localparam int BIT_LINE_COUNT = 3;
    localparam int BIT_FONT_HEIGHT = 2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic RST_BUS_8BIT = 1'b1;
    localparam logic RST_STEP_UP = 1'b1;

    typedef enum logic {ST_IDLE = 1'b0, ST_FILL = 1'b1} ctl_state_t;

endpackage : lcd_instr_pkg

// File: verilog/sync_2ff.sv
// two flip-flop synchroniser for a group of pin levels
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_ff <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : sync_2ff

// File: verilog/busy_timer.sv
// down counter that holds the busy level for a loaded number of cycles
// assumes start is a one-cycle pulse on mclk
`timescale 1ns/1ps
module busy_timer #(
    parameter int CW = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [CW-1:0] load_cycles,
    output logic busy
);
    logic [CW-1:0] count_ff;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_ff <= '0;
            busy <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start)
            begin
                count_ff <= load_cycles;
                busy <= 1'b1;
            end
            else if (count_ff > {{(CW-1){1'b0}}, 1'b1})
            begin
                count_ff <= count_ff - {{(CW-1){1'b0}}, 1'b1};
            end
            else
            begin
                count_ff <= '0;
                busy <= 1'b0;
            end
        end
    end
endmodule : busy_timer

// File: verilog/lcd_instr_decoder.sv
// instruction decoder of a character display controller: host bus, pointer, memories
// assumes host pins are asynchronous; scan inputs come from logic on mclk
`timescale 1ns/1ps
module lcd_instr_decoder
    import lcd_instr_pkg::*;
#(
    parameter int CLEAR_CYCLES = CLEAR_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic strobe_enable,
    input wire logic instr_data_select,
    input wire logic read_write,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [6:0] scan_addr,
    output logic [7:0] scan_code,
    input wire logic [5:0] glyph_addr,
    output logic [7:0] glyph_row,
    output logic panel_on,
    output logic cursor_show,
    output logic cursor_solid,
    output logic [6:0] cursor_addr,
    output logic [6:0] shift_offset,
    output logic two_line,
    output logic tall_font,
    output logic bus_8bit,
    output logic internal_operation_flag
);
    // ----------------------------------------
    // pin synchronisation and strobe edges
    // ----------------------------------------
    logic [10:0] pins_s;
    logic strobe_s, rs_s, rw_s;
    logic [7:0] din_s;
    logic strobe_d_ff;
    logic rise, fall;

    sync_2ff #(.W(11)) u_pin_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in({strobe_enable, instr_data_select, read_write, data_in}),
        .sync_out(pins_s)
    );

    assign strobe_s = pins_s[10];
    assign rs_s = pins_s[9];
    assign rw_s = pins_s[8];
    assign din_s = pins_s[7:0];
    assign rise = strobe_s & ~strobe_d_ff;
    assign fall = ~strobe_s & strobe_d_ff;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            strobe_d_ff <= 1'b0;
        else if (clk_en)
            strobe_d_ff <= strobe_s;
    end

    // ----------------------------------------
    // state and byte assembly
    // ----------------------------------------
    logic [7:0] text_mem [0:127];
    logic [7:0] glyph_mem [0:63];
    logic [6:0] ptr_ff;
    logic glyph_sel_ff, step_up_ff, auto_shift_ff;
    logic disp_on_ff, cursor_on_ff, blink_on_ff;
    logic nib_phase_ff;
    logic [3:0] hi_nib_ff;
    logic [7:0] read_latch_ff;
    logic [6:0] fill_idx_ff;
    ctl_state_t state_ff;
    logic xfer_done, cmd_wr, data_wr, data_rd;
    logic [7:0] byte_in, rd_byte;
    logic is_text_set, is_glyph_set, is_func, is_shift, is_disp, is_entry, is_home, is_clear;
    logic cursor_move, disp_move, tmr_busy, tmr_start;
    logic [6:0] ptr_step, shift_ptr, span;
    logic [BUSY_W-1:0] tmr_load;

    assign xfer_done = clk_en & fall & (bus_8bit | nib_phase_ff);
    assign byte_in = bus_8bit ? din_s : {hi_nib_ff, din_s[7:4]};
    assign cmd_wr = xfer_done & ~rs_s & ~rw_s;
    assign data_wr = xfer_done & rs_s & ~rw_s;
    assign data_rd = xfer_done & rs_s & rw_s;
    assign is_text_set = cmd_wr & byte_in[7];
    assign is_glyph_set = cmd_wr & (byte_in[7:6] == 2'b01);
    assign is_func = cmd_wr & (byte_in[7:5] == 3'b001);
    assign is_shift = cmd_wr & (byte_in[7:4] == 4'b0001);
    assign is_disp = cmd_wr & (byte_in[7:3] == 5'b00001);
    assign is_entry = cmd_wr & (byte_in[7:2] == 6'b000001);
    assign is_home = cmd_wr & (byte_in[7:1] == 7'b0000001);
    assign is_clear = cmd_wr & (byte_in == 8'h01);
    assign cursor_move = is_shift & ~byte_in[BIT_SHIFT_TARGET];
    assign disp_move = is_shift & byte_in[BIT_SHIFT_TARGET];
    assign rd_byte = rs_s ? read_latch_ff : {internal_operation_flag, ptr_ff};
    assign span = two_line ? SPAN_TWO_LINE : SPAN_ONE_LINE;

    // next pointer value with line wrap, for either direction
    function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up, input logic two,
                                            input logic glyph);
        logic [6:0] r;
        r = p;
        if (glyph)
            r = {1'b0, up ? p[5:0] + 6'd1 : p[5:0] - 6'd1};
        else if (two)
        begin
            if (up)
                r = (p == LINE1_END) ? LINE2_START : (p == LINE2_END) ? ADDR_ZERO : p + 7'd1;
            else
                r = (p == ADDR_ZERO) ? LINE2_END : (p == LINE2_START) ? LINE1_END : p - 7'd1;
        end
        else if (up)
            r = (p == ONE_LINE_END) ? ADDR_ZERO : p + 7'd1;
        else
            r = (p == ADDR_ZERO) ? ONE_LINE_END : p - 7'd1;
        return r;
    endfunction : step_ptr

    assign ptr_step = step_ptr(ptr_ff, step_up_ff, two_line, glyph_sel_ff);
    assign shift_ptr = step_ptr(ptr_ff, byte_in[BIT_SHIFT_DIR], two_line, 1'b0);

    // ----------------------------------------
    // nibble pairing and read drive
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            nib_phase_ff <= 1'b0;
            hi_nib_ff <= 4'h0;
        end
        else if (clk_en && fall)
        begin
            nib_phase_ff <= bus_8bit ? 1'b0 : ~nib_phase_ff;
            if (!nib_phase_ff)
                hi_nib_ff <= din_s[7:4];
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rise && rw_s)
            begin
                data_oe <= 1'b1;
                if (bus_8bit)
                    data_out <= rd_byte;
                else if (!nib_phase_ff)
                    data_out <= {rd_byte[7:4], 4'h0};
                else
                    data_out <= {rd_byte[3:0], 4'h0};
            end
            else if (fall)
                data_oe <= 1'b0;
        end
    end

    // ----------------------------------------
    // configuration bits
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            disp_on_ff <= 1'b0;
            cursor_on_ff <= 1'b0;
            blink_on_ff <= 1'b0;
            step_up_ff <= RST_STEP_UP;
            auto_shift_ff <= 1'b0;
            bus_8bit <= RST_BUS_8BIT;
            two_line <= 1'b0;
            tall_font <= 1'b0;
        end
        else if (clk_en)
        begin
            if (is_disp)
            begin
                disp_on_ff <= byte_in[BIT_DISP_ON];
                cursor_on_ff <= byte_in[BIT_CURSOR_ON];
                blink_on_ff <= byte_in[BIT_BLINK_ON];
            end
            if (is_entry)
            begin
                step_up_ff <= byte_in[BIT_STEP_UP];
                auto_shift_ff <= byte_in[BIT_AUTO_SHIFT];
            end
            if (is_clear)
                step_up_ff <= 1'b1;
            if (is_func)
            begin
                bus_8bit <= byte_in[BIT_BUS_WIDTH];
                two_line <= byte_in[BIT_LINE_COUNT];
                tall_font <= byte_in[BIT_FONT_HEIGHT];
            end
        end
    end

    // ----------------------------------------
    // address pointer, target memory, shift offset
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ptr_ff <= ADDR_ZERO;
            glyph_sel_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (is_text_set)
            begin
                ptr_ff <= byte_in[6:0];
                glyph_sel_ff <= 1'b0;
            end
            else if (is_glyph_set)
            begin
                ptr_ff <= {1'b0, byte_in[5:0]};
                glyph_sel_ff <= 1'b1;
            end
            else if (is_clear || is_home)
            begin
                ptr_ff <= ADDR_ZERO;
                glyph_sel_ff <= 1'b0;
            end
            else if (cursor_move)
                ptr_ff <= shift_ptr;
            else if (data_wr || data_rd)
                ptr_ff <= ptr_step;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            shift_offset <= 7'd0;
        else if (clk_en)
        begin
            if (is_clear || is_home)
                shift_offset <= 7'd0;
            else if (disp_move || (data_wr && auto_shift_ff && !glyph_sel_ff))
            begin
                // one offset for every line; cursor address stays with the content
                if (disp_move ? !byte_in[BIT_SHIFT_DIR] : step_up_ff)
                    shift_offset <= (shift_offset + 7'd1 >= span) ? 7'd0 : shift_offset + 7'd1;
                else
                    shift_offset <= (shift_offset == 7'd0) ? span - 7'd1 : shift_offset - 7'd1;
            end
        end
    end

    // ----------------------------------------
    // memories, clear fill and read prefetch
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= ST_IDLE;
            fill_idx_ff <= 7'd0;
        end
        else if (clk_en)
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (is_clear)
                    begin
                        state_ff <= ST_FILL;
                        fill_idx_ff <= 7'd0;
                    end
                end
                ST_FILL:
                begin
                    fill_idx_ff <= fill_idx_ff + 7'd1;
                    if (fill_idx_ff == FILL_LAST)
                        state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (clk_en)
        begin
            if (state_ff == ST_FILL)
                text_mem[fill_idx_ff] <= SPACE_CODE;
            else if (data_wr && !glyph_sel_ff)
                text_mem[ptr_ff] <= byte_in;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (clk_en && data_wr && glyph_sel_ff)
            glyph_mem[ptr_ff[5:0]] <= byte_in;
    end

    // output data register: filled by address set, cursor shift in text memory and each read, not by writes
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            read_latch_ff <= 8'h00;
        else if (clk_en)
        begin
            if (is_text_set)
                read_latch_ff <= text_mem[byte_in[6:0]];
            else if (is_glyph_set)
                read_latch_ff <= glyph_mem[byte_in[5:0]];
            else if (cursor_move && !glyph_sel_ff)
                read_latch_ff <= text_mem[shift_ptr];
            else if (data_rd)
                read_latch_ff <= glyph_sel_ff ? glyph_mem[ptr_step[5:0]] : text_mem[ptr_step];
        end
    end

    // ----------------------------------------
    // busy timing
    // ----------------------------------------
    assign tmr_start = cmd_wr | data_wr | data_rd;
    assign tmr_load = (is_clear || is_home) ? BUSY_W'(CLEAR_CYCLES) :
                      (data_wr || data_rd) ? BUSY_W'(DATA_CYC) : BUSY_W'(CMD_CYC);

    busy_timer #(.CW(BUSY_W)) u_busy (
        .mclk(mclk),
        .resetn(resetn),
        .clk_en(clk_en),
        .start(tmr_start),
        .load_cycles(tmr_load),
        .busy(tmr_busy)
    );

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            internal_operation_flag <= 1'b0;
        else if (clk_en)
            internal_operation_flag <= tmr_busy | tmr_start | (state_ff == ST_FILL);
    end

    // ----------------------------------------
    // panel facing outputs and blink
    // ----------------------------------------
    logic [11:0] blink_cnt_ff;
    logic blink_phase_ff;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            blink_cnt_ff <= 12'h0_000;
            blink_phase_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (blink_cnt_ff == BLINK_HALF_CYC)
            begin
                blink_cnt_ff <= 12'h0_000;
                blink_phase_ff <= ~blink_phase_ff;
            end
            else
                blink_cnt_ff <= blink_cnt_ff + 12'h0_001;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            panel_on <= 1'b0;
            cursor_show <= 1'b0;
            cursor_solid <= 1'b0;
            cursor_addr <= ADDR_ZERO;
            scan_code <= SPACE_CODE;
            glyph_row <= 8'h00;
        end
        else if (clk_en)
        begin
            panel_on <= disp_on_ff;
            cursor_show <= disp_on_ff & cursor_on_ff;
            cursor_solid <= disp_on_ff & blink_on_ff & blink_phase_ff;
            cursor_addr <= ptr_ff;
            scan_code <= disp_on_ff ? text_mem[scan_addr] : SPACE_CODE;
            glyph_row <= glyph_mem[glyph_addr];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    blank_panel_a: assert property (@(posedge mclk) disable iff (!resetn)
        clk_en && !disp_on_ff |=> scan_code == SPACE_CODE && !panel_on) else $error("blank panel shows text");
    cursor_hide_a: assert property (@(posedge mclk) disable iff (!resetn)
        clk_en && !cursor_on_ff |=> !cursor_show) else $error("hidden cursor shown");
    blink_off_a: assert property (@(posedge mclk) disable iff (!resetn)
        clk_en && !blink_on_ff |=> !cursor_solid) else $error("blink without enable");
    cursor_left_a: assert property (@(posedge mclk) disable iff (!resetn)
        cursor_move && !byte_in[BIT_SHIFT_DIR] && ptr_ff != ADDR_ZERO && ptr_ff != LINE2_START
        |=> ptr_ff == $past(ptr_ff) - 7'd1) else $error("cursor left did not decrement");
    disp_shift_a: assert property (@(posedge mclk) disable iff (!resetn)
        disp_move |=> ptr_ff == $past(ptr_ff) && shift_offset != $past(shift_offset))
        else $error("display shift wrong");
    line_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
        cursor_move && byte_in[BIT_SHIFT_DIR] && two_line && ptr_ff == LINE1_END
        |=> ptr_ff == LINE2_START) else $error("no wrap to second line");
    glyph_set_a: assert property (@(posedge mclk) disable iff (!resetn)
        is_glyph_set |=> glyph_sel_ff && ptr_ff == {1'b0, $past(byte_in[5:0])}) else $error("glyph set wrong");
    text_set_a: assert property (@(posedge mclk) disable iff (!resetn)
        is_text_set |=> !glyph_sel_ff && ptr_ff == $past(byte_in[6:0])) else $error("text set wrong");
    status_read_a: assert property (@(posedge mclk) disable iff (!resetn)
        clk_en && rise && rw_s && !rs_s && bus_8bit
        |=> data_oe && data_out == {$past(internal_operation_flag), $past(ptr_ff)}) else $error("status read wrong");
    write_step_a: assert property (@(posedge mclk) disable iff (!resetn)
        data_wr && glyph_sel_ff && step_up_ff |=> ptr_ff[5:0] == $past(ptr_ff[5:0]) + 6'd1)
        else $error("no step after write");
    write_prefetch_a: assert property (@(posedge mclk) disable iff (!resetn)
        data_wr |=> read_latch_ff == $past(read_latch_ff)) else $error("write touched read data");
    data_busy_a: assert property (@(posedge mclk) disable iff (!resetn)
        data_wr || data_rd |=> ##1 internal_operation_flag [*8]) else $error("busy too short");

    clear_seen_c: cover property (@(posedge mclk) disable iff (!resetn) is_clear ##[1:200] state_ff == ST_IDLE);
    nibble_write_c: cover property (@(posedge mclk) disable iff (!resetn) data_wr && !bus_8bit);
    data_read_c: cover property (@(posedge mclk) disable iff (!resetn) data_rd && !glyph_sel_ff);
    shift_disp_c: cover property (@(posedge mclk) disable iff (!resetn) disp_move && two_line);
endmodule : lcd_instr_decoder

// File: sim/lcd_host_model.sv
// host processor model driving the strobed parallel bus
// assumes a free-running mclk; in 4-bit mode each xfer carries one nibble on [7:4]
`timescale 1ns/1ps
module lcd_host_model (
    input wire logic mclk,
    input wire logic [7:0] data_out,
    output logic strobe_enable,
    output logic instr_data_select,
    output logic read_write,
    output logic [7:0] data_in
);
    initial
    begin
        strobe_enable = 1'b0;
        instr_data_select = 1'b0;
        read_write = 1'b0;
        data_in = 8'h00;
    end
    // one bus transfer per strobe (a nibble on [7:4] in 4-bit mode), three mclk setup
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] wv, output logic [7:0] rv);
        @(negedge mclk);
        instr_data_select = rs;
        read_write = rw;
        data_in = rw ? ~data_in : wv;
        repeat (3) @(negedge mclk);
        strobe_enable = 1'b1;
        repeat (6) @(negedge mclk);
        rv = data_out;
        strobe_enable = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : xfer
    // transfer, then poll status until idle
    task automatic cmd(input logic rs, input logic rw, input logic [7:0] wv, output logic [7:0] rv,
                       output logic [7:0] st);
        int n;
        xfer(rs, rw, wv, rv);
        st = 8'h80;
        n = 0;
        while (st[7] !== 1'b0 && n < 200)
        begin
            xfer(1'b0, 1'b1, 8'h00, st);
            n++;
        end
    endtask : cmd
endmodule : lcd_host_model

// File: sim/char_lcd_instruction_decoder_test.sv
// self-checking bench for the instruction decoder
// assumes the host model sits on the bus pins
`timescale 1ns/1ps
module char_lcd_instruction_decoder_test;
    import lcd_instr_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
    typedef struct packed {logic rs; logic [7:0] v; logic [6:0] p; logic [3:0] f;} row_t;
    logic mclk, resetn, strobe_enable, instr_data_select, read_write, data_oe;
    logic panel_on, cursor_show, cursor_solid, two_line, tall_font, bus_8bit, internal_operation_flag;
    logic [7:0] data_in, data_out, scan_code, glyph_row, rv, st;
    logic [6:0] scan_addr, cursor_addr, shift_offset;
    logic [5:0] glyph_addr;
    int mismatches = 0, n_checks = 0, cycles = 0;
    row_t rows [10] = '{
        '{1'b0, 8'h38, 7'h00, 4'h2}, '{1'b0, 8'h0E, 7'h00, 4'hE}, '{1'b0, 8'h85, 7'h05, 4'hE},
        '{1'b0, 8'h14, 7'h06, 4'hE}, '{1'b0, 8'h10, 7'h05, 4'hE}, '{1'b0, 8'hA7, 7'h27, 4'hE},
        '{1'b0, 8'h14, 7'h40, 4'hE}, '{1'b1, 8'h41, 7'h41, 4'hE}, '{1'b0, 8'h7F, 7'h3F, 4'hE},
        '{1'b0, 8'h3C, 7'h3F, 4'hF}};
    lcd_instr_decoder #(.CLEAR_CYCLES(200)) lcd_instr_decoder_inst (.mclk(mclk), .resetn(resetn),
        .clk_en(1'b1), .strobe_enable(strobe_enable), .instr_data_select(instr_data_select),
        .read_write(read_write), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .scan_addr(scan_addr), .scan_code(scan_code), .glyph_addr(glyph_addr), .glyph_row(glyph_row),
        .panel_on(panel_on), .cursor_show(cursor_show), .cursor_solid(cursor_solid),
        .cursor_addr(cursor_addr), .shift_offset(shift_offset), .two_line(two_line),
        .tall_font(tall_font), .bus_8bit(bus_8bit), .internal_operation_flag(internal_operation_flag));
    lcd_host_model lcd_host_model_inst (.mclk(mclk), .data_out(data_out), .strobe_enable(strobe_enable),
        .instr_data_select(instr_data_select), .read_write(read_write), .data_in(data_in));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            final_report();
        end
    end
    initial
    begin
        resetn = 1'b0;
        scan_addr = 7'h00;
        glyph_addr = 6'h00;
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        `CHK(data_oe, 1'b0)
        `CHK(bus_8bit, RST_BUS_8BIT)
        for (int i = 0; i < 10; i++)
        begin
            lcd_host_model_inst.cmd(rows[i].rs, 1'b0, rows[i].v, rv, st);
            `CHK(st[6:0], rows[i].p)
            `CHK({panel_on, cursor_show, two_line, tall_font}, rows[i].f)
        end
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h80, rv, st);
        lcd_host_model_inst.xfer(1'b1, 1'b0, 8'h41, rv);
        lcd_host_model_inst.xfer(1'b0, 1'b1, 8'h00, st);
        `CHK(st, 8'h81)
        lcd_host_model_inst.cmd(1'b0, 1'b1, 8'h00, rv, st);
        lcd_host_model_inst.cmd(1'b1, 1'b0, 8'h42, rv, st);
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h80, rv, st);
        lcd_host_model_inst.cmd(1'b1, 1'b1, 8'h00, rv, st);
        `CHK(rv, 8'h41)
        lcd_host_model_inst.cmd(1'b1, 1'b1, 8'h00, rv, st);
        `CHK(rv, 8'h42)
        `CHK(st[6:0], 7'h02)
        scan_addr = 7'h01;
        repeat (2) @(negedge mclk);
        `CHK(scan_code, 8'h42)
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h04, rv, st);
        lcd_host_model_inst.cmd(1'b1, 1'b0, 8'h43, rv, st);
        `CHK(st[6:0], 7'h01)
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h08, rv, st);
        `CHK({panel_on, scan_code}, {1'b0, SPACE_CODE})
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h0C, rv, st);
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h18, rv, st); // no glyph read before this shift
        `CHK({shift_offset, st[6:0], cursor_addr}, {7'h01, 7'h01, 7'h01})
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h01, rv, st);
        `CHK(st[6:0], 7'h00)
        `CHK(scan_code, SPACE_CODE)
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h40, rv, st);
        lcd_host_model_inst.cmd(1'b1, 1'b0, 8'h1F, rv, st);
        `CHK({glyph_row, st[6:0]}, {8'h1F, 7'h01})
        lcd_host_model_inst.cmd(1'b0, 1'b0, 8'h0D, rv, st);
        for (int k = 0; k < 9000 && cursor_solid !== 1'b1; k++)
            @(negedge mclk);
        `CHK({cursor_show, cursor_solid}, 2'b01)
        // switch to nibble transfers, then address, write and status in pairs
        lcd_host_model_inst.xfer(1'b0, 1'b0, 8'h28, rv);
        repeat (400) @(negedge mclk);
        `CHK(bus_8bit, 1'b0)
        lcd_host_model_inst.xfer(1'b0, 1'b0, 8'h80, rv);
        lcd_host_model_inst.xfer(1'b0, 1'b0, 8'h50, rv);
        repeat (400) @(negedge mclk);
        lcd_host_model_inst.xfer(1'b1, 1'b0, 8'h40, rv);
        lcd_host_model_inst.xfer(1'b1, 1'b0, 8'hB0, rv);
        repeat (450) @(negedge mclk);
        lcd_host_model_inst.xfer(1'b0, 1'b1, 8'h00, st);
        lcd_host_model_inst.xfer(1'b0, 1'b1, 8'h00, rv);
        `CHK({st, rv}, 16'h0060)
        scan_addr = 7'h05;
        repeat (2) @(negedge mclk);
        `CHK(scan_code, 8'h4B)
        final_report();
    end
endmodule : char_lcd_instruction_decoder_test
